//--- mode_latch_and_page0_map.v
// Purpose: strap capture, mode attributes, page-0 decode, ram control and mode readback
// Assumes: one clock; cpu byte access to the register field via acc_* ports
// Notes:   straps are captured in the first cycle after sys_rst falls
//
// Functional notes
// - mode straps captured as reset ends; selects mode 1, 2, 3, 4 or 7
// - captured pattern sets address size, rom usage and cpu mode per table
// - modes 1 and 2 reach 64 kbytes; modes 3 and 4 reach 1 Mbyte
// - single-chip frees every port and never accesses off-chip
// - modes 1, 2: ports 1, 2 control, 3 data, 4, 5 address
// - modes 3, 4: ports 1, 2 control, 3 data, 4, 5, 6 address
// - mode 2: port 5 starts as input; software turns it to output
// - mode 4: ports 5, 6 start as inputs; software turns them to output
// - modes 2 and 4 map low addresses to rom; modes 1, 3 have none
// - 64-kbyte pages; one page in min/single modes, sixteen in max
// - vectors from rom in modes 2, 4; external in modes 1, 3, 7
// - page-0 FE80 to FFFF decodes as the on-chip register field
// - ram enable set maps F680 to FE7F to ram; clear sends it off-chip except in single-chip
// - ram enable is bit 7 of ram control at FF11, bit writable
// - single-chip with ram off: ram window access is an address error
// - mode readback at FF12 is readable; writes do nothing
// - readback bits 7, 6 read one; bits 5 to 3 read zero
// - readback bits 2 to 0 return captured strap levels in order
// - max modes also save the code page on interrupt entry
`timescale 1ns/100ps
`include "mode_map.vh"

module mode_latch_and_page0_map
(
  input  wire        clk,
  input  wire        sys_rst,
  input  wire        strap_pin_hi,
  input  wire        strap_pin_mid,
  input  wire        strap_pin_lo,
  input  wire        acc_valid,
  input  wire        acc_write,
  input  wire        acc_fetch,
  input  wire [23:0] acc_addr,
  input  wire [7:0]  acc_wdata,
  output reg  [7:0]  acc_rdata,
  output reg         acc_rvalid,
  output wire        acc_reg_hit,
  output wire [2:0]  acc_target,
  output wire        acc_addr_error,
  output wire        mode_ready,
  output wire        mode_valid,
  output wire        max_mode,
  output wire        rom_on,
  output wire        single_chip,
  output wire [4:0]  page_limit,
  output wire        vectors_on_chip,
  output wire        save_code_page,
  output wire        ports12_control,
  output wire        port3_data_bus,
  output wire        port4_address,
  output wire        port5_address,
  output wire        port6_address,
  output wire        port5_starts_input,
  output wire        port6_starts_input,
  output wire        ram_enable_bit
);

  // ****************************************************************
  // state
  // ****************************************************************
  localparam [1:0] ST_RESET = 2'b01;
  localparam [1:0] ST_RUN   = 2'b10;

  reg  [1:0] state_r;
  reg  [1:0] state_nxt;
  reg  [2:0] strap_r;
  reg  [7:0] ram_control_r;
  reg  [7:0] rdata_nxt;

  wire       in_reg_field;
  wire       in_ram_win;
  wire       in_rom_win;
  wire       page0;
  wire       page_ok;
  wire       hit_ram_ctl;
  wire       hit_readback;
  wire [7:0] readback;
  reg  [2:0] target;

  function in_range;
    input [15:0] a;
    input [15:0] lo;
    input [15:0] hi;
    begin
      in_range = (a >= lo) && (a <= hi);
    end
  endfunction

  // ****************************************************************
  // strap capture on reset release
  // ****************************************************************
  always @*
  begin
    case (state_r)
      ST_RESET: state_nxt = ST_RUN;
      ST_RUN:   state_nxt = ST_RUN;
      default:  state_nxt = ST_RESET;
    endcase
  end

  always @(posedge clk)
  begin
    if (sys_rst)
    begin
      state_r <= ST_RESET;
      strap_r <= 3'h0;
    end
    else
    begin
      state_r <= state_nxt;
      if (state_r == ST_RESET)
        strap_r <= {strap_pin_hi, strap_pin_mid, strap_pin_lo};
    end
  end

  assign mode_ready = (state_r == ST_RUN);

  mode_decode u_mode_decode
  (
    .pattern     (strap_r),
    .mode_valid  (mode_valid),
    .max_mode    (max_mode),
    .rom_on      (rom_on),
    .single_chip (single_chip),
    .page_limit  (page_limit)
  );

  // ****************************************************************
  // mode attributes for the rest of the chip
  // ****************************************************************
  // single-chip keeps its rom but still takes vectors from the external table
  assign vectors_on_chip    = rom_on & ~single_chip;
  assign save_code_page     = max_mode;
  assign ports12_control    = mode_valid & ~single_chip;
  assign port3_data_bus     = mode_valid & ~single_chip;
  assign port4_address      = mode_valid & ~single_chip;
  assign port5_address      = mode_valid & ~single_chip;
  assign port6_address      = max_mode;
  assign port5_starts_input = (strap_r == `MODE_PAT_2) |
                              (strap_r == `MODE_PAT_4);
  assign port6_starts_input = (strap_r == `MODE_PAT_4);

  // ****************************************************************
  // address decode
  // ****************************************************************
  assign page0        = (acc_addr[23:16] == 8'h00);
  assign page_ok      = max_mode ? (acc_addr[23:20] == 4'h0) : page0;
  assign in_reg_field = page0 & in_range(acc_addr[15:0], `REG_FIELD_LO, `REG_FIELD_HI);
  assign in_ram_win   = page0 & in_range(acc_addr[15:0], `RAM_WIN_LO, `RAM_WIN_HI);
  assign in_rom_win   = page0 & in_range(acc_addr[15:0], 16'h0000, `ROM_WIN_HI);
  assign ram_enable_bit = ram_control_r[`RAM_ENABLE_POS];

  always @*
  begin
    if (!mode_valid || !page_ok)
      target = `TGT_ERROR;
    else if (in_reg_field)
      target = (acc_fetch) ? `TGT_ERROR : `TGT_REGS;
    else if (in_ram_win && ram_enable_bit)
      target = `TGT_RAM;
    else if (in_ram_win && single_chip)
      target = `TGT_ERROR;
    else if (in_rom_win && rom_on)
      target = `TGT_ROM;
    else if (single_chip)
      target = `TGT_ERROR;
    else
      target = `TGT_EXTERNAL;
  end

  assign acc_target     = target;
  assign acc_addr_error = acc_valid & (target == `TGT_ERROR);
  assign acc_reg_hit    = acc_valid & (target == `TGT_REGS);

  // ****************************************************************
  // register field: ram control and mode readback
  // ****************************************************************
  assign hit_ram_ctl  = acc_reg_hit & (acc_addr[15:0] == `RAM_CONTROL_ADDR);
  assign hit_readback = acc_reg_hit & (acc_addr[15:0] == `MODE_READBACK_ADDR);
  assign readback     = {`READBACK_FIXED, strap_r};

  always @(posedge clk)
  begin
    if (sys_rst)
      ram_control_r <= `RAM_CONTROL_RESET;
    else if (hit_ram_ctl && acc_write)
      ram_control_r <= {acc_wdata[`RAM_ENABLE_POS], 7'h7F};
  end

  always @*
  begin
    rdata_nxt = 8'h00;
    if (hit_ram_ctl)
      rdata_nxt = ram_control_r;
    else if (hit_readback)
      rdata_nxt = readback;
  end

  always @(posedge clk)
  begin
    if (sys_rst)
    begin
      acc_rdata  <= 8'h00;
      acc_rvalid <= 1'b0;
    end
    else
    begin
      acc_rvalid <= acc_reg_hit & ~acc_write;
      if (acc_reg_hit && !acc_write)
        acc_rdata <= rdata_nxt;
    end
  end

endmodule // mode_latch_and_page0_map

//--- mode_map.vh
// Purpose: constants for the mode latch and page-0 address map
// Assumes: 8-bit register data, 24-bit cpu address
// Notes:   included by mode_latch_and_page0_map.v and mode_decode.v
`ifndef MODE_MAP_VH
`define MODE_MAP_VH

// ****************************************************************
// register field and windows
// ****************************************************************
`define RAM_CONTROL_ADDR    16'hFF11
`define MODE_READBACK_ADDR  16'hFF12
`define REG_FIELD_LO        16'hFE80
`define REG_FIELD_HI        16'hFFFF
`define RAM_WIN_LO          16'hF680
`define RAM_WIN_HI          16'hFE7F
`define ROM_WIN_HI          16'h7FFF

// ****************************************************************
// fields and reset values
// ****************************************************************
`define RAM_ENABLE_POS      3'd7
`define RAM_CONTROL_RESET   8'h80
`define READBACK_FIXED      5'h18

// ****************************************************************
// strap patterns
// ****************************************************************
`define MODE_PAT_1          3'h1
`define MODE_PAT_2          3'h2
`define MODE_PAT_3          3'h3
`define MODE_PAT_4          3'h4
`define MODE_PAT_7          3'h7

// ****************************************************************
// target codes for the address decode
// ****************************************************************
`define TGT_EXTERNAL        3'h0
`define TGT_ROM             3'h1
`define TGT_RAM             3'h2
`define TGT_REGS            3'h3
`define TGT_ERROR           3'h4

`endif

//--- mode_decode.v
// Purpose: turns a captured strap pattern into mode attributes
// Assumes: pattern comes from the strap capture register
// Notes:   unsupported patterns give all attributes low
`timescale 1ns/100ps
`include "mode_map.vh"

module mode_decode
(
  input  wire [2:0] pattern,
  output reg        mode_valid,
  output reg        max_mode,
  output reg        rom_on,
  output reg        single_chip,
  output reg  [4:0] page_limit
);

  // ****************************************************************
  // mode table
  // ****************************************************************
  always @*
  begin
    mode_valid  = 1'b1;
    max_mode    = 1'b0;
    rom_on      = 1'b0;
    single_chip = 1'b0;
    page_limit  = 5'h01;
    case (pattern)
      `MODE_PAT_1: rom_on = 1'b0;
      `MODE_PAT_2: rom_on = 1'b1;
      `MODE_PAT_3:
      begin
        max_mode   = 1'b1;
        page_limit = 5'h10;
      end
      `MODE_PAT_4:
      begin
        max_mode   = 1'b1;
        rom_on     = 1'b1;
        page_limit = 5'h10;
      end
      `MODE_PAT_7:
      begin
        rom_on      = 1'b1;
        single_chip = 1'b1;
      end
      default:
      begin
        mode_valid = 1'b0;
        page_limit = 5'h00;
      end
    endcase
  end

endmodule // mode_decode

//--- strap_board.sv
// Purpose: board model for the three mode strap pins
// Assumes: mode_sel changes only while sys_rst is high
// Notes:   pins reload only during reset and then hold
`timescale 1ns/100ps
module strap_board
(
  input  wire       clk,
  input  wire       sys_rst,
  input  wire [2:0] mode_sel,
  output reg        strap_pin_hi,
  output reg        strap_pin_mid,
  output reg        strap_pin_lo
);
  // unsupported patterns are never put on the pins
  always @(posedge clk)
  begin
    if (sys_rst && mode_sel != 3'h0 && mode_sel != 3'h5 && mode_sel != 3'h6)
      {strap_pin_hi, strap_pin_mid, strap_pin_lo} <= mode_sel;
  end
endmodule // strap_board

//--- mode_latch_props.sv
// Purpose: port assertions for the mode latch and page-0 map
// Assumes: straps steady while running
// Notes:   bound to the top module below
`timescale 1ns/100ps
module mode_latch_props
(
  input logic        clk,
  input logic        sys_rst,
  input logic        strap_pin_hi,
  input logic        strap_pin_mid,
  input logic        strap_pin_lo,
  input logic        acc_valid,
  input logic        acc_write,
  input logic        acc_fetch,
  input logic [23:0] acc_addr,
  input logic [7:0]  acc_wdata,
  input logic [7:0]  acc_rdata,
  input logic        acc_rvalid,
  input logic        acc_reg_hit,
  input logic [2:0]  acc_target,
  input logic        mode_ready,
  input logic        max_mode,
  input logic        single_chip,
  input logic [4:0]  page_limit,
  input logic        save_code_page,
  input logic        ram_enable_bit
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  wire [2:0] pat = {strap_pin_hi, strap_pin_mid, strap_pin_lo};
  wire       wd7 = acc_wdata[7];
  wire       win = acc_addr >= 24'h00F680 && acc_addr <= 24'h00FE7F;
  // ********
  // checks
  // ********
  chk_capture_on_release: assert property (
    $fell(sys_rst) |=> mode_ready) else $error("straps not captured");
  chk_read_answer: assert property (
    acc_valid && !acc_write && !acc_fetch && acc_reg_hit |=> acc_rvalid)
    else $error("read not answered");
  chk_readback_value: assert property (
    acc_rvalid && $past(acc_addr) == 24'h00FF12 |-> acc_rdata == {5'h18, pat})
    else $error("bad mode readback");
  chk_ram_bit_write: assert property (
    acc_valid && acc_write && acc_addr == 24'h00FF11 |=> ram_enable_bit == $past(wd7))
    else $error("ram enable not written");
  chk_ram_window_on: assert property (
    mode_ready && win && ram_enable_bit |-> acc_target == 3'h2) else $error("ram not mapped");
  chk_ram_window_off: assert property (
    mode_ready && win && !ram_enable_bit |-> acc_target == (single_chip ? 3'h4 : 3'h0))
    else $error("ram window off target wrong");
  chk_page_count: assert property (
    mode_ready |-> page_limit == (max_mode ? 5'h10 : 5'h01)) else $error("bad page limit");
  chk_max_and_save: assert property (
    mode_ready |-> max_mode == (pat == 3'h3 || pat == 3'h4) && save_code_page == max_mode)
    else $error("max mode mismatch");
  chk_no_offchip: assert property (
    mode_ready && single_chip |-> acc_target != 3'h0) else $error("off-chip in single-chip");
  chk_space_limit: assert property (
    mode_ready && acc_addr[23:20] != 4'h0 |-> acc_target == 3'h4) else $error("beyond 1 Mbyte");
endmodule // mode_latch_props

bind mode_latch_and_page0_map mode_latch_props u_props
(
  .clk, .sys_rst, .strap_pin_hi, .strap_pin_mid, .strap_pin_lo, .acc_valid, .acc_write,
  .acc_fetch, .acc_addr, .acc_wdata, .acc_rdata, .acc_rvalid, .acc_reg_hit, .acc_target,
  .mode_ready, .max_mode, .single_chip, .page_limit, .save_code_page, .ram_enable_bit
);

//--- testbench.sv
// Purpose: self-checking bench for the mode latch and page-0 map
// Assumes: byte accesses, one per request cycle
// Notes:   every mode is booted in turn
`timescale 1ns/100ps
module testbench;
  logic        clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic [2:0]  mode_sel = 3'h1;
  logic        acc_valid = 1'b0;
  logic        acc_write = 1'b0;
  logic        acc_fetch = 1'b0;
  logic [23:0] acc_addr = 24'h000000;
  logic [7:0]  acc_wdata = 8'h00;
  logic [2:0]  modes [0:4] = '{3'h1, 3'h2, 3'h3, 3'h4, 3'h7};
  logic [2:0]  m;
  logic        mx, rm, sc;
  integer      n_mismatch = 0;
  integer      n_tests = 0;
  wire         strap_pin_hi, strap_pin_mid, strap_pin_lo, acc_rvalid, acc_reg_hit;
  wire         acc_addr_error, mode_ready, mode_valid, max_mode, rom_on, single_chip;
  wire         vectors_on_chip, save_code_page, ports12_control, port3_data_bus;
  wire         port4_address, port5_address, port6_address, port5_starts_input;
  wire         port6_starts_input, ram_enable_bit;
  wire  [7:0]  acc_rdata;
  wire  [2:0]  acc_target;
  wire  [4:0]  page_limit;

  always #2.5 clk = ~clk;
  strap_board u_board (.clk, .sys_rst, .mode_sel, .strap_pin_hi, .strap_pin_mid, .strap_pin_lo);
  mode_latch_and_page0_map u_dut
  (
    .clk, .sys_rst, .strap_pin_hi, .strap_pin_mid, .strap_pin_lo, .acc_valid, .acc_write,
    .acc_fetch, .acc_addr, .acc_wdata, .acc_rdata, .acc_rvalid, .acc_reg_hit, .acc_target,
    .acc_addr_error, .mode_ready, .mode_valid, .max_mode, .rom_on, .single_chip,
    .page_limit, .vectors_on_chip, .save_code_page, .ports12_control, .port3_data_bus,
    .port4_address, .port5_address, .port6_address, .port5_starts_input,
    .port6_starts_input, .ram_enable_bit
  );
  // ********
  // tasks
  // ********
  task cmp(input logic [7:0] got, input logic [7:0] exp);
  begin
    n_tests = n_tests + 1;
    if (got !== exp)
    begin
      n_mismatch = n_mismatch + 1;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  end
  endtask
  task acc(input logic wr, input logic [23:0] a, input logic [7:0] d);
  begin
    @(negedge clk);
    acc_valid = 1'b1;
    acc_write = wr;
    acc_addr = a;
    acc_wdata = d;
    @(negedge clk);
    acc_valid = 1'b0;
  end
  endtask
  task rd(input logic [23:0] a, input logic [7:0] exp);
  begin
    acc(1'b0, a, 8'h00);
    cmp(acc_rvalid, 8'h01);
    cmp(acc_rdata, exp);
  end
  endtask
  task probe(input logic f, input logic [23:0] a, input logic [4:0] exp);
  begin
    @(negedge clk);
    acc_valid = 1'b1;
    acc_write = 1'b0;
    acc_fetch = f;
    acc_addr = a;
    #1;
    cmp({acc_addr_error, acc_reg_hit, acc_target}, exp);
    @(negedge clk);
    acc_valid = 1'b0;
    acc_fetch = 1'b0;
  end
  endtask
  task tgt(input logic [23:0] a, input logic [2:0] exp);
  begin
    @(negedge clk);
    acc_addr = a;
    #1;
    cmp(acc_target, exp);
  end
  endtask
  task stop_test;
  begin
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  end
  endtask
  // ********
  // tests
  // ********
  initial
  begin
    for (int i = 0; i < 5; i++)
    begin
      m = modes[i];
      @(negedge clk);
      sys_rst = 1'b1;
      mode_sel = m;
      repeat (10) @(negedge clk);
      sys_rst = 1'b0;
      repeat (2) @(negedge clk);
      mx = m == 3'h3 || m == 3'h4;
      rm = m == 3'h2 || m == 3'h4 || m == 3'h7;
      sc = m == 3'h7;
      cmp({mode_valid, max_mode, rom_on, single_chip, save_code_page, port6_address,
           vectors_on_chip, ram_enable_bit}, {1'b1, mx, rm, sc, mx, mx, rm && !sc, 1'b1});
      cmp({ports12_control, port3_data_bus, port4_address, port5_address,
           port5_starts_input, port6_starts_input, mode_ready, 1'b0},
          {!sc, !sc, !sc, !sc, m == 3'h2 || m == 3'h4, m == 3'h4, 2'b10});
      cmp(page_limit, mx ? 8'h10 : 8'h01);
      rd(24'h00FF12, {5'h18, m});
      acc(1'b1, 24'h00FF12, 8'h00);
      rd(24'h00FF12, {5'h18, m});
      tgt(24'h00FE80, 3'h3);
      tgt(24'h00F680, 3'h2);
      tgt(24'h000000, rm ? 3'h1 : 3'h0);
      tgt(24'h008000, sc ? 3'h4 : 3'h0);
      tgt(24'h0F0000, mx ? 3'h0 : 3'h4);
      tgt(24'h100000, 3'h4);
      probe(1'b1, 24'h00FE80, 5'h14);
      probe(1'b0, 24'h00FE80, 5'h0B);
      probe(1'b0, 24'h008000, sc ? 5'h14 : 5'h00);
      rd(24'h00FF20, 8'h00);
      acc(1'b1, 24'h00FF11, 8'h00);
      rd(24'h00FF11, 8'h7F);
      tgt(24'h00FE7F, sc ? 3'h4 : 3'h0);
      acc(1'b1, 24'h00FF11, 8'h80);
      rd(24'h00FF11, 8'hFF);
    end
    stop_test;
  end
  // watchdog well beyond the expected run
  initial
  begin
    repeat (2000) @(posedge clk);
    n_mismatch = n_mismatch + 1;
    stop_test;
  end
endmodule // testbench
